// *** hdl/wet_pkg.sv ***
// package: register map, field layout, action codes and carrier types for the edge timing memory
package wet_pkg;

  // register indexes; byte address is four times the index
  localparam logic [29:0] IDX_ADDR = 30'h0000_0005;
  localparam logic [2:0][29:0] IDX_FINE = {30'h0000_000a, 30'h0000_0008, 30'h0000_0006};
  localparam logic [2:0][29:0] IDX_COARSE = {30'h0000_000b, 30'h0000_0009, 30'h0000_0007};

  // geometry
  localparam int unsigned NUM_EDGES = 3;
  localparam int unsigned NUM_ENTRIES = 256;

  // field positions
  localparam int unsigned FINE_HI = 15;
  localparam int unsigned FINE_LO = 10;
  localparam int unsigned ACT_HI = 3;
  localparam int unsigned ACT_LO = 0;
  localparam int unsigned PADDR_HI = 7;
  localparam int unsigned INC_HI = 9;
  localparam int unsigned INC_LO = 8;

  // timing: one coarse count is one reference period, split into 64 fine steps
  localparam real REF_PERIOD_NS = 2.5;
  localparam int unsigned FINE_STEPS = 64;
  localparam real FINE_STEP_PS = REF_PERIOD_NS * 1000.0 / FINE_STEPS;
  localparam int unsigned ACK_LATENCY = 1;

  // the one edge that has no window-open codes
  localparam logic [1:0] EDGE_NO_WIN = 2'h1;

  // raw action codes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_DRV_LOW = 4'h1;
  localparam logic [3:0] ACT_DRV_HIGH = 4'h2;
  localparam logic [3:0] ACT_FRC_OFF = 4'h3;
  localparam logic [3:0] ACT_FRC_ON = 4'h4;
  localparam logic [3:0] ACT_FRC_DOWN = 4'h5;
  localparam logic [3:0] ACT_FRC_UP = 4'h6;
  localparam logic [3:0] ACT_CMP_LOW = 4'h7;
  localparam logic [3:0] ACT_CMP_HIGH = 4'h8;
  localparam logic [3:0] ACT_CMP_OFF = 4'h9;
  localparam logic [3:0] ACT_CMP_VALID = 4'ha;
  localparam logic [3:0] ACT_WIN_LOW = 4'hb;
  localparam logic [3:0] ACT_WIN_HIGH = 4'hc;
  localparam logic [3:0] ACT_WIN_Z = 4'hd;
  localparam logic [3:0] ACT_WIN_VALID = 4'he;
  localparam logic [3:0] ACT_CMP_UNK = 4'hf;

  // decoded action
  typedef enum logic [4:0] {
    WET_NONE = 5'h00,
    WET_DRV_LOW = 5'h01,
    WET_DRV_HIGH = 5'h02,
    WET_FRC_OFF = 5'h03,
    WET_FRC_ON = 5'h04,
    WET_FRC_DOWN = 5'h05,
    WET_FRC_UP = 5'h06,
    WET_CMP_LOW = 5'h07,
    WET_CMP_HIGH = 5'h08,
    WET_CMP_OFF = 5'h09,
    WET_CMP_VALID = 5'h0a,
    WET_WIN_LOW = 5'h0b,
    WET_WIN_HIGH = 5'h0c,
    WET_WIN_Z = 5'h0d,
    WET_WIN_VALID = 5'h0e,
    WET_CMP_UNK = 5'h0f,
    WET_CLOSE_UNK = 5'h10
  } wet_act_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wet_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wet_wb_rsp_t;

  typedef struct packed {
    logic [5:0] fine;
    logic [3:0] action;
  } wet_fa_t;

  typedef struct packed {
    wet_fa_t fa;
    logic [15:0] coarse;
  } wet_entry_t;

  typedef struct packed {
    logic fire;
    wet_act_t act;
    logic [21:0] place;
  } wet_edge_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] addr;
    logic [1:0] inc_sel;
    wet_fa_t [2:0] stage;
    wet_entry_t [255:0][2:0] mem;
    logic [2:0] busy;
    logic [2:0][15:0] cnt;
    wet_entry_t [2:0] run;
    wet_edge_t [2:0] edges;
  } wet_state_t;

  localparam wet_state_t STATE_RST = '0;

endpackage

// *** hdl/wet_edge_mem.sv ***
// waveform edge timing memory: wishbone register bank, entry store and edge placement counters
//
// Notes on behaviour
// R1: edge 0 coarse field counts 2.5 ns reference periods before the edge.
// R2: after the edge 0 count, fine delay is added to give the placement.
// R3: software writes edge 0 fine/action just before edge 0 coarse.
// R4: edge 1 counts coarse periods, then adds its fine delay.
// R5: software writes edge 1 fine/action just before edge 1 coarse.
// R6: edge 1 fine delay is bits 15:10, unsigned, 1/64 of a period.
// R7: action 0 none, 1 low, 2 high, 3..6 force off, on, down, up.
// R8: actions 7..10 compare low, high, off, valid.
// R9: edge 1 code 15 closes window or marks unknown; 11..14 undefined.
// R10: edge 2 fine delay is bits 15:10, 2.5 ns over 64 per step.
// R11: edge 2 codes 11..14 open window low, high, high-Z, valid.
// R12: edge 2 code 15 is compare unknown; 0..10 as other edges.
// R13: 8-bit address selects the entry; reads return the current address and select.
// R14: 2-bit select picks which edge's coarse access bumps the address.
// R15: fine/action write is staged, committed with coarse on coarse write.
`timescale 1ns/1ps
`default_nettype none

module wet_edge_mem (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire wet_pkg::wet_wb_req_t wb_req_i,
  output var wet_pkg::wet_wb_rsp_t wb_rsp_o,
  // playback
  input wire logic start_i,
  input wire logic [7:0] wf_sel_i,
  input wire logic ref_tick_i,
  output var wet_pkg::wet_edge_t [2:0] edge_o
);

  wet_pkg::wet_state_t s_q;
  wet_pkg::wet_state_t s_d;
  logic req;
  logic [29:0] idx;
  logic [15:0] wval;
  wet_pkg::wet_entry_t ent;

  function automatic logic [15:0] wet_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    wet_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic wet_pkg::wet_act_t wet_decode(input logic [3:0] code, input logic [1:0] e);
    wet_pkg::wet_act_t r;
    r = wet_pkg::WET_NONE;
    case (code)
      wet_pkg::ACT_NONE: r = wet_pkg::WET_NONE;
      wet_pkg::ACT_DRV_LOW: r = wet_pkg::WET_DRV_LOW;
      wet_pkg::ACT_DRV_HIGH: r = wet_pkg::WET_DRV_HIGH;
      wet_pkg::ACT_FRC_OFF: r = wet_pkg::WET_FRC_OFF;
      wet_pkg::ACT_FRC_ON: r = wet_pkg::WET_FRC_ON;
      wet_pkg::ACT_FRC_DOWN: r = wet_pkg::WET_FRC_DOWN;
      wet_pkg::ACT_FRC_UP: r = wet_pkg::WET_FRC_UP;
      wet_pkg::ACT_CMP_LOW: r = wet_pkg::WET_CMP_LOW;
      wet_pkg::ACT_CMP_HIGH: r = wet_pkg::WET_CMP_HIGH;
      wet_pkg::ACT_CMP_OFF: r = wet_pkg::WET_CMP_OFF;
      wet_pkg::ACT_CMP_VALID: r = wet_pkg::WET_CMP_VALID;
      wet_pkg::ACT_WIN_LOW: r = wet_pkg::WET_WIN_LOW;
      wet_pkg::ACT_WIN_HIGH: r = wet_pkg::WET_WIN_HIGH;
      wet_pkg::ACT_WIN_Z: r = wet_pkg::WET_WIN_Z;
      wet_pkg::ACT_WIN_VALID: r = wet_pkg::WET_WIN_VALID;
      wet_pkg::ACT_CMP_UNK: r = wet_pkg::WET_CMP_UNK;
      default: r = wet_pkg::WET_NONE;
    endcase
    // edge 1 has no window opens; undefined codes are treated as no action
    if (e == wet_pkg::EDGE_NO_WIN) begin
      if (code >= wet_pkg::ACT_WIN_LOW && code <= wet_pkg::ACT_WIN_VALID) begin
        r = wet_pkg::WET_NONE; // R9
      end
      if (code == wet_pkg::ACT_CMP_UNK) begin
        r = wet_pkg::WET_CLOSE_UNK; // R9
      end
    end
    return r;
  endfunction

  assign req = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
  assign idx = wb_req_i.adr[31:2];

  always_comb begin
    s_d = s_q;
    wval = 16'h0000;
    ent = '0;
    if (ce_i) begin
      s_d.ack = 1'b0;
      s_d.rdata = 32'h0000_0000;
      for (int e = 0; e < 3; e++) begin
        s_d.edges[e].fire = 1'b0;
      end

      // register access; unmapped addresses ack with zero data
      if (req) begin
        s_d.ack = 1'b1;
        if (idx == wet_pkg::IDX_ADDR) begin
          if (wb_req_i.we) begin
            wval = wet_merge({6'h00, s_q.inc_sel, s_q.addr}, wb_req_i.dat, wb_req_i.sel);
            s_d.addr = wval[wet_pkg::PADDR_HI:0]; // R13
            s_d.inc_sel = wval[wet_pkg::INC_HI:wet_pkg::INC_LO]; // R14
          end else begin
            s_d.rdata = {22'h00_0000, s_q.inc_sel, s_q.addr}; // R13
          end
        end
        for (int e = 0; e < 3; e++) begin
          ent = s_q.mem[s_q.addr][e];
          if (idx == wet_pkg::IDX_FINE[e]) begin
            if (wb_req_i.we) begin
              wval = wet_merge({s_q.stage[e].fine, 6'h00, s_q.stage[e].action},
                               wb_req_i.dat, wb_req_i.sel);
              // staged only; a later coarse write moves it into the entry
              s_d.stage[e].fine = wval[wet_pkg::FINE_HI:wet_pkg::FINE_LO]; // R6 R10 R15
              s_d.stage[e].action = wval[wet_pkg::ACT_HI:wet_pkg::ACT_LO]; // R15
            end else begin
              s_d.rdata = {16'h0000, ent.fa.fine, 6'h00, ent.fa.action}; // R6 R10
            end
          end
          if (idx == wet_pkg::IDX_COARSE[e]) begin
            if (wb_req_i.we) begin
              s_d.mem[s_q.addr][e].coarse = wet_merge(ent.coarse, wb_req_i.dat, wb_req_i.sel);
              s_d.mem[s_q.addr][e].fa = s_q.stage[e]; // R15
            end else begin
              s_d.rdata = {16'h0000, ent.coarse};
            end
            // reads and writes both advance the address when this edge is selected
            if (s_q.inc_sel == 2'(e)) begin
              s_d.addr = s_q.addr + 8'h01; // R14
            end
          end
        end
      end

      // edge placement: coarse count in reference ticks, then fine added
      for (int e = 0; e < 3; e++) begin
        if (start_i) begin
          // restart wins over a count in flight
          s_d.busy[e] = 1'b1;
          s_d.run[e] = s_q.mem[wf_sel_i][e];
          s_d.cnt[e] = s_q.mem[wf_sel_i][e].coarse; // R1 R4
        end else if (s_q.busy[e] && ref_tick_i) begin
          if (s_q.cnt[e] == 16'h0000) begin
            s_d.busy[e] = 1'b0;
            s_d.edges[e].fire = 1'b1; // R1 R4
            // coarse times 64 plus fine, in fine steps
            s_d.edges[e].place = {s_q.run[e].coarse, s_q.run[e].fa.fine}; // R2 R4
            s_d.edges[e].act = wet_decode(s_q.run[e].fa.action, 2'(e)); // R7 R8 R11 R12
          end else begin
            s_d.cnt[e] = s_q.cnt[e] - 16'h0001; // R1 R4
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= wet_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdata;
  assign edge_o = s_q.edges;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_acc;
    req && ce_i;
  endsequence

  sequence s_rd_addr;
    req && ce_i && !wb_req_i.we && idx == wet_pkg::IDX_ADDR;
  endsequence

  bus_ack_a: assert property (s_acc |=> wb_rsp_o.ack)
    else $error("no ack one cycle after request");
  ack_single_a: assert property ((wb_rsp_o.ack && ce_i) |=> !wb_rsp_o.ack)
    else $error("ack held longer than one cycle");
  addr_read_a: assert property (s_rd_addr |=> wb_rsp_o.dat == // R13
    {22'h00_0000, $past(s_q.inc_sel), $past(s_q.addr)})
    else $error("address readback wrong");

  for (genvar g = 0; g < 3; g++) begin : g_chk
    sequence s_coarse;
      req && ce_i && idx == wet_pkg::IDX_COARSE[g];
    endsequence
    sequence s_fire;
      edge_o[g].fire;
    endsequence

    fine_field_a: assert property ((req && ce_i && !wb_req_i.we && idx == wet_pkg::IDX_FINE[g])
      |=> wb_rsp_o.dat[9:4] == 6'h00 && // R6 R10
      wb_rsp_o.dat[15:10] == $past(s_q.mem[s_q.addr][g].fa.fine))
      else $error("fine field readback wrong");
    entry_commit_a: assert property ((s_coarse and wb_req_i.we) |=> // R15
      s_q.mem[$past(s_q.addr)][g].fa == $past(s_q.stage[g]) &&
      s_q.mem[$past(s_q.addr)][g].coarse == $past(wb_req_i.dat[15:0]) ||
      $past(wb_req_i.sel[1:0]) != 2'h3)
      else $error("coarse write did not commit staged value");
    addr_inc_a: assert property ((s_coarse and s_q.inc_sel == 2'(g)) |=> // R14
      s_q.addr == $past(s_q.addr) + 8'h01)
      else $error("address did not advance");
    addr_hold_a: assert property ((s_coarse and s_q.inc_sel != 2'(g)) |=> // R14
      s_q.addr == $past(s_q.addr))
      else $error("address advanced for wrong edge");
    count_load_a: assert property ((start_i && ce_i) |=> s_q.busy[g] && // R1 R4
      s_q.cnt[g] == $past(s_q.mem[wf_sel_i][g].coarse))
      else $error("coarse count not loaded");
    fire_cause_a: assert property (s_fire |-> // R1 R4
      $past(ref_tick_i && ce_i && !start_i && s_q.busy[g] && s_q.cnt[g] == 16'h0000))
      else $error("edge fired before count ran out");
    place_sum_a: assert property (s_fire |-> // R2
      edge_o[g].place == 22'(s_q.run[g].coarse) * 22'h00_0040 + 22'(s_q.run[g].fa.fine))
      else $error("placement is not coarse plus fine");
    act_drive_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_FRC_UP)
      |-> edge_o[g].act == wet_pkg::WET_FRC_UP) // R7
      else $error("force up decoded wrong");
    act_compare_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_CMP_VALID)
      |-> edge_o[g].act == wet_pkg::WET_CMP_VALID) // R8
      else $error("compare valid decoded wrong");
    if (g == 1) begin : g_e1
      e1_undef_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_WIN_HIGH)
        |-> edge_o[g].act == wet_pkg::WET_NONE) // R9
        else $error("edge 1 undefined code not ignored");
      e1_close_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_CMP_UNK)
        |-> edge_o[g].act == wet_pkg::WET_CLOSE_UNK) // R9
        else $error("edge 1 close code decoded wrong");
    end
    if (g == 2) begin : g_e2
      e2_window_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_WIN_Z)
        |-> edge_o[g].act == wet_pkg::WET_WIN_Z) // R11
        else $error("edge 2 window code decoded wrong");
      e2_unknown_a: assert property ((s_fire and s_q.run[g].fa.action == wet_pkg::ACT_CMP_UNK)
        |-> edge_o[g].act == wet_pkg::WET_CMP_UNK) // R12
        else $error("edge 2 unknown code decoded wrong");
    end
  end

endmodule

`default_nettype wire

// *** sim/wet_edge_mem_tb.sv ***
// testbench: register programming, readback and edge playback of the edge timing memory
`timescale 1ns/1ps
`default_nettype none

module wet_edge_mem_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic start_i = 1'b0;
  logic ref_tick_i = 1'b1;
  logic [7:0] wf_sel_i = 8'h00;
  wet_pkg::wet_wb_req_t req = '0;
  wet_pkg::wet_wb_rsp_t rsp;
  wet_pkg::wet_edge_t [2:0] edges;
  int errors = 0;
  int n_tests = 0;

  always #4 clk_i = ~clk_i;

  wet_edge_mem i_wet_edge_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_req_i(req),
    .wb_rsp_o(rsp),
    .start_i(start_i),
    .wf_sel_i(wf_sel_i),
    .ref_tick_i(ref_tick_i),
    .edge_o(edges)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one classic cycle; ack and data are taken at the same edge
  task automatic wb(input logic w, input logic [29:0] idx, input logic [15:0] wd,
                    output logic [15:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h3, dat: {16'h0000, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1);
    chk("wb ack", {31'h0000_0000, rsp.ack}, 32'h0000_0001);
    rdat = rsp.dat[15:0];
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [15:0] d);
    logic [15:0] dummy;
    wb(1'b1, idx, d, dummy);
  endtask

  task automatic rdc(input string what, input logic [29:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    wb(1'b0, idx, 16'h0000, v);
    chk(what, {16'h0000, v}, {16'h0000, exp});
  endtask

  // edge 1 lacks the window-open codes and closes on 15
  function automatic wet_pkg::wet_act_t exp_act(input int e, input logic [3:0] c);
    if (e == 1 && c == 4'hf) return wet_pkg::WET_CLOSE_UNK;
    if (e == 1 && c >= 4'hb) return wet_pkg::WET_NONE;
    return wet_pkg::wet_act_t'({1'b0, c});
  endfunction

  // ticks held off for gap cycles after start, then every cycle
  task automatic play(input logic [7:0] w, input logic [15:0] coarse, input logic [3:0] c,
                      input int gap);
    int n;
    n = 0;
    @(posedge clk_i);
    start_i <= 1'b1;
    wf_sel_i <= w;
    ref_tick_i <= (gap == 0);
    do begin
      @(posedge clk_i);
      start_i <= 1'b0;
      n++;
      if (n == gap) begin
        ref_tick_i <= 1'b1;
      end
    end while (edges[0].fire !== 1'b1 && n < 40);
    chk("fire delay", n, 32'(coarse) + 32'(gap > 1 ? gap + 2 : 3));
    for (int e = 0; e < 3; e++) begin
      chk("fire", {31'h0000_0000, edges[e].fire}, 32'h0000_0001);
      chk("act", 32'(edges[e].act), 32'(exp_act(e, c)));
      chk("place", 32'(edges[e].place), 32'({coarse, 6'(c * 4 + e)}));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("addr reset", wet_pkg::IDX_ADDR, 16'h0000);
    wr(wet_pkg::IDX_ADDR, 16'h0200);
    for (int c = 0; c < 16; c++) begin
      for (int e = 0; e < 3; e++) begin
        wr(wet_pkg::IDX_FINE[e], {6'(c * 4 + e), 6'h00, 4'(c)});
        wr(wet_pkg::IDX_COARSE[e], 16'(c + 1));
      end
    end
    rdc("addr after fill", wet_pkg::IDX_ADDR, 16'h0210);
    for (int c = 0; c < 16; c++) begin
      play(8'(c), 16'(c + 1), 4'(c), (c % 4 == 3) ? 5 : 0);
    end
    // select 3 means no coarse access of this block moves the address
    wr(wet_pkg::IDX_ADDR, 16'h0305);
    rdc("fine1 readback", wet_pkg::IDX_FINE[1], 16'h5405);
    rdc("coarse2 readback", wet_pkg::IDX_COARSE[2], 16'h0006);
    rdc("addr edge3 sel", wet_pkg::IDX_ADDR, 16'h0305);
    wr(wet_pkg::IDX_FINE[0], 16'hfc0a);
    rdc("fine0 staged only", wet_pkg::IDX_FINE[0], 16'h5005);
    wr(wet_pkg::IDX_COARSE[0], 16'h0077);
    rdc("fine0 committed", wet_pkg::IDX_FINE[0], 16'hfc0a);
    rdc("coarse0 committed", wet_pkg::IDX_COARSE[0], 16'h0077);
    wr(wet_pkg::IDX_ADDR, 16'h00ff);
    rdc("coarse1 no inc", wet_pkg::IDX_COARSE[1], 16'h0000);
    rdc("coarse0 inc", wet_pkg::IDX_COARSE[0], 16'h0000);
    rdc("addr wrapped", wet_pkg::IDX_ADDR, 16'h0000);
    rdc("coarse0 entry0", wet_pkg::IDX_COARSE[0], 16'h0001);
    rdc("addr inc", wet_pkg::IDX_ADDR, 16'h0001);
    wr(30'h0000_0040, 16'hffff);
    rdc("unmapped", 30'h0000_0040, 16'h0000);
    rdc("addr kept", wet_pkg::IDX_ADDR, 16'h0001);
    give_verdict();
  end

  // the whole sequence needs well under ten thousand cycles
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
